// ==== design/onchip_sram_subsystem.sv ====
// Controller joining the instruction-fetch and load/store sides to one
// single-port SRAM. Assumes requests are one-cycle pulses synchronous to
// mclk_i and that unanswered requests are taken by the system bus path.
`timescale 1ns/1ns
module onchip_sram_subsystem
  import sram_ctrl_pkg::*;
(
  input  wire logic               mclk_i,
  input  wire logic               nrst_i,
  // Configuration
  input  wire logic [RANGE_W-1:0] instr_range_field_i,
  input  wire logic [RANGE_W-1:0] data_range_field_i,
  input  wire logic               instr_side_enable_i,
  input  wire logic               data_side_enable_i,
  input  wire logic               instr_two_cycle_select_i,
  input  wire logic               cfg_we_i,
  input  wire logic               little_endian_i,
  // Instruction side
  input  wire logic               fetch_req_i,
  input  wire logic [ADDR_W-1:0]  fetch_addr_i,
  output logic                    fetch_hit_o,
  output logic                    fetch_wait_o,
  output logic                    fetch_valid_o,
  output logic      [WORD_W-1:0]  fetch_data_o,
  // Data side, then configuration readback and store-queue status
  input  wire logic               load_req_i,
  input  wire logic               store_req_i,
  input  wire logic [ADDR_W-1:0]  data_addr_i,
  input  wire logic [BE_W-1:0]    store_be_i,
  input  wire logic [WORD_W-1:0]  store_data_i,
  output logic                    data_hit_o,
  output logic                    load_valid_o,
  output logic      [WORD_W-1:0]  load_data_o,
  output logic      [RANGE_W-1:0] instr_range_o,
  output logic      [RANGE_W-1:0] data_range_o,
  output logic                    instr_enable_o,
  output logic                    data_enable_o,
  output logic                    two_cycle_o,
  output logic                    store_pending_o
);
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic in_window(input logic [ADDR_W-1:0] a,
                                     input logic [RANGE_W-1:0] r,
                                     input logic en);
    in_window = en && (a[ADDR_W-1:RANGE_LSB] == r);
  endfunction

  function automatic logic [WORD_W-1:0] swap(input logic [WORD_W-1:0] d);
    swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [RANGE_W-1:0] irange_r, drange_r;
  logic               ien_r, den_r, two_cyc_r, le_r;

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irange_r  <= RANGE_RST;
      drange_r  <= RANGE_RST;
      ien_r     <= EN_RST;
      den_r     <= EN_RST;
      two_cyc_r <= TWO_CYC_RST;
      le_r      <= 1'b0;
    end else if (cfg_we_i) begin
      irange_r  <= instr_range_field_i;
      drange_r  <= data_range_field_i;
      ien_r     <= instr_side_enable_i;
      den_r     <= data_side_enable_i;
      two_cyc_r <= instr_two_cycle_select_i;
      le_r      <= little_endian_i;
    end
  end

  assign instr_range_o  = irange_r;
  assign data_range_o   = drange_r;
  assign instr_enable_o = ien_r;
  assign data_enable_o  = den_r;
  assign two_cycle_o    = two_cyc_r;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  wire i_hit = fetch_req_i &&
               in_window(fetch_addr_i, irange_r, ien_r);
  wire d_hit = in_window(data_addr_i, drange_r, den_r);
  wire ld    = load_req_i && d_hit;
  wire st    = store_req_i && d_hit && !load_req_i;

  assign fetch_hit_o = i_hit;
  assign data_hit_o  = (load_req_i || store_req_i) && d_hit;

  // ----------------------------------------------------------------------
  // Store queue
  // ----------------------------------------------------------------------
  logic               sq_v_r;
  logic [BYP_W-1:0]   sq_a_r;
  logic [BE_W-1:0]    sq_be_r;
  logic [WORD_W-1:0]  sq_d_r;
  wire  [WORD_W-1:0]  st_word = le_r ? swap(store_data_i) : store_data_i;
  wire  [BE_W-1:0]    st_be   = le_r ? {store_be_i[0], store_be_i[1],
                                        store_be_i[2], store_be_i[3]}
                                     : store_be_i;
  // A store that meets a load goes to the queue; the load goes first, the queue drains once no load is present
  wire sq_drain = sq_v_r && !ld;
  wire st_now   = st && !sq_v_r && !ld;
  wire st_queue = store_req_i && d_hit && (ld || load_req_i || sq_v_r);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sq_v_r  <= 1'b0;
      sq_a_r  <= '0;
      sq_be_r <= '0;
      sq_d_r  <= '0;
    end else if (st_queue) begin
      sq_v_r  <= 1'b1;
      sq_a_r  <= data_addr_i[BYP_LSB +: BYP_W];
      sq_be_r <= st_be;
      sq_d_r  <= st_word;
    end else if (sq_drain) begin
      sq_v_r  <= 1'b0;
    end
  end
  assign store_pending_o = sq_v_r;

  // ----------------------------------------------------------------------
  // Arbiter and shared port
  // ----------------------------------------------------------------------
  logic              i_pend_r;
  logic [MEM_AW-1:0] i_addr_r;
  wire  data_busy = ld || st_now || sq_drain;
  wire  i_ask     = i_hit || i_pend_r;
  // Two-cycle mode spends one cycle capturing the request before the port
  wire  i_go      = !data_busy && (two_cyc_r ? i_pend_r : i_ask);
  wire  [MEM_AW-1:0] i_word = i_hit ? fetch_addr_i[WADDR_LSB +: MEM_AW]
                                    : i_addr_r;
  wire  port_en = ld || st_now || sq_drain || i_go;
  wire  port_we = !ld && (st_now || sq_drain);
  wire  [MEM_AW-1:0] port_a =
          ld       ? data_addr_i[WADDR_LSB +: MEM_AW] :
          sq_drain ? sq_a_r[MEM_AW-1:0] :
          st_now   ? data_addr_i[WADDR_LSB +: MEM_AW] : i_word;
  wire  [BE_W-1:0]   port_be = sq_drain ? sq_be_r : st_be;
  wire  [WORD_W-1:0] port_d  = sq_drain ? sq_d_r  : st_word;
  logic [WORD_W-1:0] arr_q;

  sram_array u_array (
    .mclk_i  (mclk_i),
    .en_i    (port_en),
    .we_i    (port_we),
    .be_i    (port_be),
    .addr_i  (port_a),
    .wdata_i (port_d),
    .rdata_o (arr_q)
  );

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      i_pend_r <= 1'b0;
      i_addr_r <= '0;
    end else begin
      i_pend_r <= ien_r && i_ask && !i_go;
      if (i_hit) begin
        i_addr_r <= fetch_addr_i[WADDR_LSB +: MEM_AW];
      end
    end
  end
  assign fetch_wait_o = i_ask && !i_go;

  // ----------------------------------------------------------------------
  // Return path
  // ----------------------------------------------------------------------
  logic              ld_q_r, fe_q_r, byp_r, le_q_r;
  logic [WORD_W-1:0] byp_d_r;
  logic [BE_W-1:0]   byp_be_r;
  wire  byp_hit = ld && sq_v_r &&
                  (data_addr_i[BYP_LSB +: BYP_W] == sq_a_r);

  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ld_q_r   <= 1'b0;
      fe_q_r   <= 1'b0;
      byp_r    <= 1'b0;
      le_q_r   <= 1'b0;
      byp_d_r  <= '0;
      byp_be_r <= '0;
    end else begin
      ld_q_r   <= ld;
      fe_q_r   <= i_go;
      byp_r    <= byp_hit;
      le_q_r   <= le_r;
      byp_d_r  <= sq_d_r;
      byp_be_r <= sq_be_r;
    end
  end

  logic [WORD_W-1:0] merged;
  genvar g;
  generate
    for (g = 0; g < BE_W; g++) begin : g_merge
      assign merged[g*8 +: 8] = (byp_r && byp_be_r[g]) ?
                                byp_d_r[g*8 +: 8] : arr_q[g*8 +: 8];
    end
  endgenerate

  // Straight to the core, never through a cache
  assign load_valid_o  = ld_q_r;
  assign load_data_o   = le_q_r ? swap(merged) : merged;
  assign fetch_valid_o = fe_q_r;
  assign fetch_data_o  = arr_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  load_one_cyc_a: assert property (ld |=> load_valid_o)
    else $error("load not answered in one cycle");
  load_first_a: assert property (ld |-> !port_we && port_en)
    else $error("load lost the port");
  store_defer_a: assert property (store_req_i && d_hit && load_req_i
                                  |=> store_pending_o)
    else $error("store not queued behind load");
  queue_drain_a: assert property (sq_v_r && !ld |=> !sq_v_r || $past(st_queue))
    else $error("queue not drained");
  fetch_one_a: assert property (!two_cyc_r && i_hit && !data_busy
                                |=> fetch_valid_o)
    else $error("fetch not one cycle");
  fetch_two_a: assert property (two_cyc_r && i_hit && !i_pend_r
                                |=> !fetch_valid_o)
    else $error("two-cycle fetch too early");
  fetch_gate_a: assert property (fetch_hit_o |-> ien_r &&
                    fetch_addr_i[ADDR_W-1:RANGE_LSB] == irange_r)
    else $error("fetch hit outside window");
  data_gate_a: assert property (data_hit_o |-> den_r)
    else $error("data hit while disabled");
  starve_a: assert property (ld && i_ask |-> !i_go)
    else $error("fetch beat a load");
  reset_en_a: assert property ($rose(nrst_i) |-> !ien_r && two_cyc_r)
    else $error("bad reset config");

  load_c: cover property (ld ##1 load_valid_o);
  bypass_c: cover property (byp_hit);
  fetch_c: cover property (i_go ##1 fetch_valid_o);
  defer_c: cover property (st_queue ##1 ld ##1 sq_drain);
endmodule

// ==== include/sram_ctrl_pkg.sv ====
// Package for the on-chip SRAM controller: address fields and timing.
// Assumes big-endian bit numbering of effective addresses is mapped to
// Verilog bit 31 - n by the instantiating core.
package sram_ctrl_pkg;
  // ----------------------------------------------------------------------
  // Address layout (Verilog bit numbers, 31 = most significant)
  // ----------------------------------------------------------------------
  localparam int ADDR_W      = 32;
  localparam int RANGE_W     = 6;
  localparam int RANGE_LSB   = 26;
  localparam int WORD_W      = 32;
  localparam int MEM_AW      = 10;   // 4KB as 1024 words
  localparam int WADDR_LSB   = 2;    // byte bits of the word address
  localparam int BYP_W       = 12;   // bits 18:29 in big-endian numbering
  localparam int BYP_LSB     = 2;
  localparam int BE_W        = 4;
  localparam logic [RANGE_W-1:0] RANGE_RST = 6'h00;
  localparam logic               TWO_CYC_RST = 1'b1;
  localparam logic               EN_RST = 1'b0;
endpackage

// ==== design/sram_array.sv ====
// Single-port word array with per-byte write enables.
// Assumes one access per cycle; read data appears one edge later.
`timescale 1ns/1ns
module sram_array
  import sram_ctrl_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              en_i,
  input  wire logic              we_i,
  input  wire logic [BE_W-1:0]   be_i,
  input  wire logic [MEM_AW-1:0] addr_i,
  input  wire logic [WORD_W-1:0] wdata_i,
  output logic      [WORD_W-1:0] rdata_o
);
  // One byte-wide array per lane, so that each lane has a single writer
  genvar b;
  generate
    for (b = 0; b < BE_W; b++) begin : g_lane
      logic [7:0] mem [0:(1<<MEM_AW)-1];

      always_ff @(posedge mclk_i) begin
        if (en_i && we_i && be_i[b]) begin
          mem[addr_i] <= wdata_i[b*8 +: 8];
        end
        if (en_i && !we_i) begin
          rdata_o[b*8 +: 8] <= mem[addr_i];
        end
      end
    end
  endgenerate
endmodule

// ==== tb/core_model.sv ====
// Model of the core's fetch and load/store units facing the controller.
// Assumes the bench calls step once per cycle; lines change on falling
// edges only.
`timescale 1ns/1ns
module core_model
  import sram_ctrl_pkg::*;
(
  input  wire logic              mclk_i,
  output logic                   fetch_req_o,
  output logic      [ADDR_W-1:0] fetch_addr_o,
  output logic                   load_req_o,
  output logic                   store_req_o,
  output logic      [ADDR_W-1:0] data_addr_o,
  output logic      [BE_W-1:0]   store_be_o,
  output logic      [WORD_W-1:0] store_data_o
);
  initial begin
    {fetch_req_o, load_req_o, store_req_o} = 3'h0;
    {fetch_addr_o, data_addr_o, store_be_o, store_data_o} = '0;
  end

  // -------------------------------------------------------------------
  // One cycle of requests
  // -------------------------------------------------------------------
  // Idle lines invert so that a stale address or datum never matches
  task automatic step(input logic ld, st, fe,
                      input logic [ADDR_W-1:0] da, fa,
                      input logic [BE_W-1:0]   be,
                      input logic [WORD_W-1:0] wd);
    @(negedge mclk_i);
    load_req_o   = ld;
    store_req_o  = st;
    fetch_req_o  = fe;
    data_addr_o  = (ld | st) ? da : ~data_addr_o;
    fetch_addr_o = fe ? fa : ~fetch_addr_o;
    store_be_o   = st ? be : ~store_be_o;
    store_data_o = st ? wd : ~store_data_o;
  endtask
endmodule

// ==== tb/onchip_sram_subsystem_tb.sv ====
// Bench for the on-chip SRAM controller: a table of single transfers,
// then reset, store queueing, bypass, fetch modes and starvation.
// Assumes the core model drives requests on falling edges of mclk_i.
`timescale 1ns/1ns
module onchip_sram_subsystem_tb
  import sram_ctrl_pkg::*;
();
  typedef struct packed {
    logic [2:0]  op;
    logic [31:0] addr;
    logic [3:0]  be;
    logic [31:0] data;
  } row_s;
  localparam logic [31:0] DW = 32'hFC00_0000;
  localparam logic [31:0] IW = 32'h1400_0000;
  localparam logic [31:0] A  = DW + 32'h0000_0200;
  logic mclk_i, nrst_i, cfg_we_i, little_endian_i;
  logic [5:0] instr_range_field_i, data_range_field_i;
  logic instr_side_enable_i, data_side_enable_i, instr_two_cycle_select_i;
  logic fetch_req_i, load_req_i, store_req_i;
  logic [31:0] fetch_addr_i, data_addr_i, store_data_i;
  logic [3:0]  store_be_i;
  logic fetch_hit_o, fetch_wait_o, fetch_valid_o, data_hit_o, load_valid_o;
  logic [31:0] fetch_data_o, load_data_o;
  logic [5:0]  instr_range_o, data_range_o;
  logic instr_enable_o, data_enable_o, two_cycle_o, store_pending_o;
  int fails = 0;
  int n_checks = 0;
  // Op: 0 store, 1 load, 2 fetch, 5 load outside, 6 fetch outside
  row_s rows [12] = '{
    '{3'd0, DW + 32'h0000_0100, 4'hF, 32'h1111_2222},
    '{3'd0, DW + 32'h0000_0104, 4'hF, 32'hAAAA_5555},
    '{3'd0, DW + 32'h0000_0104, 4'h1, 32'h0000_00CC},
    '{3'd0, A, 4'hF, 32'h0123_4567},
    '{3'd1, DW + 32'h0000_0100, 4'h0, 32'h1111_2222},
    '{3'd1, DW + 32'h0000_1104, 4'h0, 32'hAAAA_55CC},
    '{3'd2, IW + 32'h0000_0103, 4'h0, 32'h1111_2222},
    '{3'd2, IW + 32'h0000_0106, 4'h0, 32'hAAAA_55CC},
    '{3'd5, 32'hF800_0100, 4'h0, 32'h0000_0000},
    '{3'd6, 32'h1800_0104, 4'h0, 32'h0000_0000},
    '{3'd6, DW + 32'h0000_0100, 4'h0, 32'h0000_0000},
    '{3'd5, IW + 32'h0000_0100, 4'h0, 32'h0000_0000}};

  onchip_sram_subsystem onchip_sram_subsystem_inst (.*);
  core_model core_model_inst (
    .mclk_i       (mclk_i),
    .fetch_req_o  (fetch_req_i),
    .fetch_addr_o (fetch_addr_i),
    .load_req_o   (load_req_i),
    .store_req_o  (store_req_i),
    .data_addr_o  (data_addr_i),
    .store_be_o   (store_be_i),
    .store_data_o (store_data_i)
  );

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic go(input logic ld, st, fe, input logic [31:0] a);
    core_model_inst.step(ld, st, fe, a, a, 4'hF, 32'h5A5A_0001);
  endtask
  task automatic cfg(input logic [5:0] ir, dr, input logic ie, de, tc);
    @(negedge mclk_i);
    {instr_range_field_i, data_range_field_i} = {ir, dr};
    {instr_side_enable_i, data_side_enable_i} = {ie, de};
    {instr_two_cycle_select_i, cfg_we_i} = {tc, 1'b1};
    @(negedge mclk_i);
    cfg_we_i = 1'b0;
  endtask
  task automatic chk_rst;
    chk({instr_range_o, data_range_o, instr_enable_o, data_enable_o,
         two_cycle_o, store_pending_o, load_valid_o, fetch_valid_o},
        {RANGE_RST, RANGE_RST, 2'b00, 1'b1, 3'b000});
  endtask
  task automatic run_row(input row_s r);
    logic ld, st, fe;
    ld = (r.op[1:0] == 2'd1);
    st = (r.op == 3'd0);
    fe = (r.op[1:0] == 2'd2);
    core_model_inst.step(ld, st, fe, r.addr, r.addr, r.be, r.data);
    #1 chk(fe ? fetch_hit_o : data_hit_o, !r.op[2]);
    go(0, 0, 0, '0);
    chk(fe ? fetch_valid_o : load_valid_o, !r.op[2] & !st);
    if (!r.op[2] & !st) chk(fe ? fetch_data_o : load_data_o, r.data);
    if (st) chk(store_pending_o, 1'b0);
    go(0, 0, 0, '0);
  endtask

  // -------------------------------------------------------------------
  // Clock, watchdog and main sequence
  // -------------------------------------------------------------------
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    #100_000;
    fails++;
    complete_run;
  end
  initial begin
    {nrst_i, cfg_we_i, little_endian_i} = 3'b000;
    {instr_range_field_i, data_range_field_i} = '0;
    {instr_side_enable_i, data_side_enable_i} = 2'b00;
    instr_two_cycle_select_i = 1'b1;
    repeat (6) @(negedge mclk_i);
    chk_rst;
    nrst_i = 1'b1;
    cfg(6'h05, 6'h3F, 1'b1, 1'b1, 1'b0);
    chk({instr_range_o, data_range_o, instr_enable_o, data_enable_o,
         two_cycle_o}, {12'h17F, 2'b11, 1'b0});
    foreach (rows[i]) run_row(rows[i]);
    // Store meets a load: queued, bypassed at 16KB alias only
    go(1, 1, 0, A);
    go(1, 0, 0, A + 32'h0000_4000);
    chk({load_valid_o, store_pending_o}, 2'b11);
    go(1, 0, 0, A + 32'h0000_1000);
    chk(load_data_o, 32'h5A5A_0001);
    go(0, 0, 0, '0);
    chk(load_data_o, 32'h0123_4567);
    go(1, 0, 0, A);
    chk(store_pending_o, 1'b0);
    go(0, 0, 0, '0);
    chk(load_data_o, 32'h5A5A_0001);
    // Fetch starved by a run of loads
    core_model_inst.step(1, 0, 1, A, IW + 32'h0000_0100, 4'h0, '0);
    for (int i = 0; i < 3; i++) begin
      go(i < 2, 0, 0, A);
      #1 chk(fetch_valid_o, 1'b0);
      if (i == 0) chk(fetch_wait_o, 1'b1);
    end
    go(0, 0, 0, '0);
    chk(fetch_valid_o, 1'b1);
    chk(fetch_data_o, 32'h1111_2222);
    // Two-cycle fetch mode
    cfg(6'h05, 6'h3F, 1'b1, 1'b1, 1'b1);
    core_model_inst.step(0, 0, 1, '0, IW + 32'h0000_0104, 4'h0, '0);
    go(0, 0, 0, '0);
    chk(fetch_valid_o, 1'b0);
    for (int i = 0; i < 4 && fetch_valid_o !== 1'b1; i++) go(0, 0, 0, '0);
    chk(fetch_valid_o, 1'b1);
    chk(fetch_data_o, 32'hAAAA_55CC);
    // Little-endian data side; fetches still see the array big-endian
    little_endian_i = 1'b1;
    cfg(6'h05, 6'h3F, 1'b1, 1'b1, 1'b0);
    core_model_inst.step(0, 1, 0, A, '0, 4'hF, 32'h5A5A_0001);
    core_model_inst.step(0, 1, 0, A, '0, 4'h1, 32'h0000_00CC);
    core_model_inst.step(0, 0, 1, '0, IW + 32'h0000_0200, 4'h0, '0);
    core_model_inst.step(1, 0, 0, A, '0, 4'h0, '0);
    chk(fetch_valid_o, 1'b1);
    chk(fetch_data_o, 32'hCC00_5A5A);
    go(0, 0, 0, '0);
    chk(load_data_o, 32'h5A5A_00CC);
    // Both sides disabled: in-window requests go unanswered
    cfg(6'h05, 6'h3F, 1'b0, 1'b0, 1'b0);
    core_model_inst.step(1, 0, 1, A, IW, 4'h0, '0);
    #1 chk({fetch_hit_o, data_hit_o}, 2'b00);
    go(0, 0, 0, '0);
    chk({fetch_valid_o, load_valid_o}, 2'b00);
    cfg(6'h05, 6'h3F, 1'b1, 1'b1, 1'b0);
    nrst_i = 1'b0;
    #10 chk_rst;
    complete_run;
  end
endmodule
